/* rtl/sync_serial_spi_status_defs.vh */
// register map, field positions, reset values and mode codes of the serial port
// included by the port and read by the bench; definitions only
`ifndef SYNC_SERIAL_SPI_STATUS_DEFS_VH
`define SYNC_SERIAL_SPI_STATUS_DEFS_VH

// register addresses
`define ADR_STATUS     4'h0
`define ADR_CONTROL    4'h1
`define ADR_BUFFER     4'h2
`define ADR_OWN_ADDR   4'h3
`define ADR_IRQ_STAT   4'h4
`define ADR_IRQ_MASK   4'h5
`define ADR_PINS       4'h6

// status fields
`define ST_SMP         7
`define ST_CKE         6
`define ST_DA          5
`define ST_STOP        4
`define ST_START       3
`define ST_RW          2
`define ST_UA          1
`define ST_BF          0

// control fields
`define CT_EN          5
`define CT_CKP         4
`define CT_MODE_HI     3
`define CT_MODE_LO     0

// interrupt status and mask fields
`define IRQ_DONE       0
`define IRQ_START      1
`define IRQ_STOP       2

// reset values
`define STATUS_RST     2'h0
`define CONTROL_RST    6'h00
`define OWN_ADDR_RST   8'h00
`define IRQ_RST        3'h0

// mode codes
`define MODE_MST_DIV4  4'h0
`define MODE_MST_DIV16 4'h1
`define MODE_MST_DIV64 4'h2
`define MODE_MST_LAST  4'h3
`define MODE_SLV_SS    4'h4
`define MODE_SLV_NOSS  4'h5
`define MODE_I2C_SLV7  4'h6

// master half period in ref_clk cycles, minus one
`define HALF_DIV4      5'h01
`define HALF_DIV16     5'h07
`define HALF_DIV64     5'h1F
// master ticks per word: 16 clock edges plus a closing tick
`define MST_LAST_TICK  5'h10
`define LAST_BIT       4'h7
`define I2C_ACK_BIT    4'h8

`endif

/* rtl/pin_sync.v */
// two flip-flop synchroniser for pins that arrive from outside ref_clk
// assumes inputs are plain levels; no reset so the chain settles by itself
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter WIDTH = 3
) (
    input  wire             ref_clk,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge ref_clk) begin
        meta_q <= async_i;
        sync_o <= meta_q;
    end
endmodule // pin_sync
`default_nettype wire

/* rtl/sync_serial_spi_status.v */
// synchronous serial port: spi master/slave and 7-bit i2c slave with status register
// assumes one ref_clk domain; all pins are sampled through pin_sync
//
// Functional notes
// - two modes, spi and i2c, picked by the mode field of control
// - spi shifts 8 bits out while shifting 8 bits in, same transfer
// - master drives sck, slave takes sck from the remote master
// - clock rate used only as master; slave select used only as slave
// - slave mode may use a slave select pin driven by the master
// - clock edge bit 1 launches on active-to-idle, 0 on idle-to-active
// - i2c data/address bit: 1 last byte data, 0 address
// - i2c stop bit: 1 when a stop was seen last
// - i2c start bit: 1 when a start was seen last; 0 after reset
// - i2c direction bit holds r/w of last matching address
// - receive: buffer full set when byte lands, cleared when empty
// - i2c transmit: buffer full while sending, cleared when sent
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_spi_status_defs.vh"
module sync_serial_spi_status (
    input  wire       ref_clk,
    input  wire       rstn,
    input  wire [3:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr_en,
    input  wire       rd_en,
    output reg  [7:0] rdata,
    output wire       irq,
    input  wire       sck_i,
    output wire       sck_o,
    output wire       sck_oe_n,
    input  wire       sdi_i,
    output wire       sdo_o,
    output wire       sdo_oe_n,
    input  wire       ss_n_i,
    output wire       sda_o,
    output wire       sda_oe_n
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    function is_master;
        input [3:0] m;
        is_master = (m <= `MODE_MST_LAST);
    endfunction

    function [4:0] half_cnt;
        input [3:0] m;
        case (m)
            `MODE_MST_DIV4:  half_cnt = `HALF_DIV4;
            `MODE_MST_DIV16: half_cnt = `HALF_DIV16;
            default:         half_cnt = `HALF_DIV64;
        endcase
    endfunction

    // synchronised pins
    wire [2:0] pins_s;
    wire       s_sck = pins_s[0];
    wire       s_sdi = pins_s[1];
    wire       s_ss_n = pins_s[2];

    pin_sync #(.WIDTH(3)) u_sync (
        .ref_clk (ref_clk),
        .async_i ({ss_n_i, sdi_i, sck_i}),
        .sync_o  (pins_s)
    );

    // registers
    reg [5:0] ctl_q;
    reg       smp_q, cke_q;
    reg [7:0] own_addr_q, rxbuf_q;
    reg       bf_q, da_q, stop_q, start_q, rw_q;
    reg [2:0] irq_stat_q, irq_mask_q;
    // shift engine
    reg [1:0] st_q;
    reg [4:0] div_q, tick_q;
    reg [3:0] bit_q;
    reg [7:0] tx_sh_q, rx_sh_q;
    reg       sck_q, sdo_q, sda_low_q;
    reg       sck_p_q, sdi_p_q;
    // i2c
    reg       i2_act_q, i2_addr_ph_q;

    wire       en   = ctl_q[`CT_EN];
    wire       idle_clock_level  = ctl_q[`CT_CKP];
    wire [3:0] mode = ctl_q[`CT_MODE_HI:`CT_MODE_LO];
    wire       mst  = en & is_master(mode);
    wire       slv  = en & ((mode == `MODE_SLV_SS) | (mode == `MODE_SLV_NOSS));
    wire       i2c  = en & (mode == `MODE_I2C_SLV7);
    // select pin only counts in slave mode with select enabled
    wire       ss_act = (mode != `MODE_SLV_SS) | ~s_ss_n;

    wire sck_rise = s_sck & ~sck_p_q;
    wire sck_fall = ~s_sck & sck_p_q;
    wire lead     = idle_clock_level ? sck_fall : sck_rise;
    wire trail    = idle_clock_level ? sck_rise : sck_fall;

    // master tick decode
    wire m_tick   = (st_q == ST_RUN) & (div_q == 5'h00);
    wire t_odd    = tick_q[0];
    wire t_edge   = (tick_q != `MST_LAST_TICK);
    wire m_launch = m_tick & t_edge & (cke_q ? t_odd : ~t_odd);
    wire m_sample = m_tick & (smp_q ? (cke_q ? t_odd : (~t_odd & (tick_q != 5'h00)))
                                    : (cke_q ? (~t_odd & t_edge) : t_odd));
    wire m_done   = m_tick & ~t_edge;

    // slave edge decode; edge parity follows the idle level
    wire s_launch = slv & ss_act & (cke_q ? trail : lead);
    wire s_sample = slv & ss_act & (cke_q ? lead : trail);
    wire s_done   = s_sample & (bit_q == `LAST_BIT);

    // i2c bus conditions: scl high while sda moves
    wire i2_start = i2c & s_sck & sck_p_q & sdi_p_q & ~s_sdi;
    wire i2_stop  = i2c & s_sck & sck_p_q & ~sdi_p_q & s_sdi;
    wire i2_rise  = i2c & sck_rise;
    wire i2_fall  = i2c & sck_fall;
    wire i2_end   = i2_fall & (bit_q == `I2C_ACK_BIT);
    wire i2_match = (rx_sh_q[7:1] == own_addr_q[7:1]);
    wire i2_rx    = i2_end & (i2_addr_ph_q ? i2_match : (i2_act_q & ~rw_q));
    wire i2_tx    = i2_end & ~i2_addr_ph_q & i2_act_q & rw_q;

    wire rx_done  = m_done | s_done | i2_rx;
    wire buf_wr   = wr_en & (addr == `ADR_BUFFER);
    wire buf_rd   = rd_en & (addr == `ADR_BUFFER);
    wire [2:0] irq_set = {i2_stop, i2_start, rx_done | i2_tx};

    assign irq      = |(irq_stat_q & irq_mask_q);
    assign sck_o    = sck_q;
    assign sck_oe_n = ~mst;
    assign sdo_o    = sdo_q;
    assign sdo_oe_n = ~(mst | (slv & ss_act));
    assign sda_o    = 1'b0;
    assign sda_oe_n = ~sda_low_q;

    // register writes and status flags
    always @(posedge ref_clk) begin
        if (!rstn) begin
            ctl_q      <= `CONTROL_RST;
            {smp_q, cke_q} <= `STATUS_RST;
            own_addr_q <= `OWN_ADDR_RST;
            irq_mask_q <= `IRQ_RST;
            irq_stat_q <= `IRQ_RST;
            bf_q       <= 1'b0;
            da_q       <= 1'b0;
            stop_q     <= 1'b0;
            start_q    <= 1'b0;
            rw_q       <= 1'b0;
        end else begin
            if (wr_en && addr == `ADR_CONTROL)
                ctl_q <= wdata[5:0];
            if (wr_en && addr == `ADR_STATUS) begin
                smp_q <= wdata[`ST_SMP];
                cke_q <= wdata[`ST_CKE];
            end
            if (wr_en && addr == `ADR_OWN_ADDR)
                own_addr_q <= wdata;
            if (wr_en && addr == `ADR_IRQ_MASK)
                irq_mask_q <= wdata[2:0];
            // set wins over the read clear
            irq_stat_q <= ((rd_en && addr == `ADR_IRQ_STAT) ? `IRQ_RST : irq_stat_q) | irq_set;
            // buffer full: byte landed wins over the emptying read
            if (rx_done)
                bf_q <= 1'b1;
            else if (i2c && buf_wr && rw_q)
                bf_q <= 1'b1;
            else if (i2_tx)
                bf_q <= 1'b0;
            else if (buf_rd && !(i2c && rw_q))
                bf_q <= 1'b0;
            if (i2_rx)
                da_q <= ~i2_addr_ph_q;
            if (!en) begin
                start_q <= 1'b0;
                stop_q  <= 1'b0;
            end else if (i2_start) begin
                start_q <= 1'b1;
                stop_q  <= 1'b0;
            end else if (i2_stop) begin
                start_q <= 1'b0;
                stop_q  <= 1'b1;
            end
            // direction is only meaningful until the next bus condition
            if (i2_start || i2_stop || !en)
                rw_q <= 1'b0;
            else if (i2_end && i2_addr_ph_q && i2_match)
                rw_q <= rx_sh_q[0];
        end
    end

    // shift engine for all modes
    always @(posedge ref_clk) begin
        if (!rstn) begin
            st_q         <= ST_IDLE;
            div_q        <= 5'h00;
            tick_q       <= 5'h00;
            bit_q        <= 4'h0;
            tx_sh_q      <= 8'h00;
            rx_sh_q      <= 8'h00;
            rxbuf_q      <= 8'h00;
            sck_q        <= 1'b0;
            sdo_q        <= 1'b0;
            sda_low_q    <= 1'b0;
            sck_p_q      <= 1'b0;
            sdi_p_q      <= 1'b1;
            i2_act_q     <= 1'b0;
            i2_addr_ph_q <= 1'b0;
        end else begin
            sck_p_q <= s_sck;
            sdi_p_q <= s_sdi;
            // slave: the eighth bit lands in the same cycle as the copy
            if (rx_done)
                rxbuf_q <= s_done ? {rx_sh_q[6:0], s_sdi} : rx_sh_q;
            case (st_q)
                ST_IDLE: begin
                    sck_q <= idle_clock_level;
                    // a write during a master transfer is dropped
                    if (buf_wr && (mst || slv || i2c)) begin
                        tx_sh_q <= cke_q ? {wdata[6:0], 1'b0} : wdata;
                        bit_q   <= 4'h0;
                        if (cke_q && !i2c)
                            sdo_q <= wdata[7];
                        if (mst) begin
                            st_q   <= ST_RUN;
                            div_q  <= half_cnt(mode);
                            tick_q <= 5'h00;
                        end
                        if (i2c)
                            tx_sh_q <= wdata;
                    end
                    if (slv && !ss_act)
                        bit_q <= 4'h0;
                    if (s_launch) begin
                        sdo_q   <= tx_sh_q[7];
                        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                    end
                    if (s_sample) begin
                        rx_sh_q <= {rx_sh_q[6:0], s_sdi};
                        bit_q   <= s_done ? 4'h0 : bit_q + 4'h1;
                    end
                end
                ST_RUN: begin
                    if (!mst) begin
                        st_q <= ST_IDLE;
                    end else if (m_tick) begin
                        div_q  <= half_cnt(mode);
                        tick_q <= tick_q + 5'h01;
                        if (t_edge)
                            sck_q <= ~sck_q;
                        if (m_done)
                            st_q <= ST_IDLE;
                    end else begin
                        div_q <= div_q - 5'h01;
                    end
                    if (m_launch) begin
                        sdo_q   <= tx_sh_q[7];
                        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                    end
                    if (m_sample)
                        rx_sh_q <= {rx_sh_q[6:0], s_sdi};
                end
                default: st_q <= ST_IDLE;
            endcase
            // i2c slave, 7-bit address, no clock stretching
            if (!i2c) begin
                sda_low_q    <= 1'b0;
                i2_act_q     <= 1'b0;
                i2_addr_ph_q <= 1'b0;
            end else if (i2_start) begin
                bit_q        <= 4'h0;
                i2_act_q     <= 1'b0;
                i2_addr_ph_q <= 1'b1;
                sda_low_q    <= 1'b0;
            end else if (i2_stop) begin
                i2_act_q     <= 1'b0;
                i2_addr_ph_q <= 1'b0;
                sda_low_q    <= 1'b0;
            end else if (i2_rise) begin
                if (bit_q == `I2C_ACK_BIT) begin
                    bit_q <= 4'h0;
                    // master nack ends a read
                    if (i2_act_q && rw_q && s_sdi)
                        i2_act_q <= 1'b0;
                end else begin
                    rx_sh_q <= {rx_sh_q[6:0], s_sdi};
                    bit_q   <= bit_q + 4'h1;
                end
            end else if (i2_fall) begin
                if (bit_q == `I2C_ACK_BIT) begin
                    sda_low_q <= i2_rx;
                    if (i2_addr_ph_q) begin
                        i2_act_q     <= i2_match;
                        i2_addr_ph_q <= 1'b0;
                    end
                end else if (i2_act_q && rw_q) begin
                    sda_low_q <= ~tx_sh_q[7];
                    tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
                end else begin
                    sda_low_q <= 1'b0;
                end
            end
        end
    end

    // read data stand one cycle after the strobe, zero otherwise
    always @(posedge ref_clk) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `ADR_STATUS:   rdata <= {smp_q, cke_q, da_q, stop_q,
                                         start_q, rw_q, 1'b0, bf_q};
                `ADR_CONTROL:  rdata <= {2'h0, ctl_q};
                `ADR_BUFFER:   rdata <= rxbuf_q;
                `ADR_OWN_ADDR: rdata <= own_addr_q;
                `ADR_IRQ_STAT: rdata <= {5'h00, irq_stat_q};
                `ADR_IRQ_MASK: rdata <= {5'h00, irq_mask_q};
                `ADR_PINS:     rdata <= {5'h00, s_ss_n, s_sdi, s_sck};
                default:       rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // sync_serial_spi_status
`default_nettype wire

/* dv/spi_peer.sv */
// spi slave peer facing the port while it runs as master
// assumes clock idles low; act is high while the port drives the clock
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
    input  wire logic       sck,
    input  wire logic       act,
    input  wire logic       cke,
    input  wire logic       load,
    input  wire logic [7:0] tx,
    input  wire logic       sdo,
    output logic            sdi,
    output logic [7:0]      rx
);
    logic [8:0] sh_q = 9'h000;
    initial rx = 8'h00;
    // released line shows the inverse, never a held value
    assign sdi = act ? sh_q[8] : ~sh_q[8];
    always @(posedge load) sh_q = cke ? {tx, 1'b0} : {1'b0, tx};
    // launch on the edge cke picks, sample on the other
    always @(posedge sck) if (act) begin
        if (cke) rx = {rx[6:0], sdo};
        else sh_q = sh_q << 1;
    end
    always @(negedge sck) if (act) begin
        if (cke) sh_q = sh_q << 1;
        else rx = {rx[6:0], sdo};
    end
endmodule // spi_peer
`default_nettype wire

/* dv/sync_serial_spi_status_chk.sv */
// assertions on pins and register read bus of the serial port
// assumes a bind into sync_serial_spi_status; one ref_clk domain
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_spi_status_defs.vh"
module sync_serial_spi_status_chk (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic [3:0] addr,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    input wire logic       irq,
    input wire logic       sck_o,
    input wire logic       sck_oe_n,
    input wire logic       sdo_oe_n,
    input wire logic       sda_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_rd_idle; !$past(rd_en) |-> rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_mst_sdo; !sck_oe_n |-> !sdo_oe_n; endproperty
    a_mst_sdo: assert property (p_mst_sdo) else $error("master clock without data");
    // shortest half period is two cycles
    property p_half; !sck_oe_n && !$past(sck_oe_n) && $changed(sck_o) |=> $stable(sck_o);
    endproperty
    a_half: assert property (p_half) else $error("clock half period too short");
    property p_ctl; $past(rd_en) && $past(addr) == `ADR_CONTROL |-> rdata[7:6] == 2'b00;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control top bits set");
    property p_unmap; $past(rd_en) && $past(addr) > `ADR_PINS |-> rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_pins; $past(rd_en) && $past(addr) == `ADR_PINS |-> rdata[7:3] == 5'h00;
    endproperty
    a_pins: assert property (p_pins) else $error("pin read top bits set");
    property p_sda_slv; !sda_oe_n |-> sck_oe_n; endproperty
    a_sda_slv: assert property (p_sda_slv) else $error("clock driven in i2c slave");
    property p_irq_rd; $past(rd_en) && $past(addr) == `ADR_IRQ_STAT |-> rdata[7:3] == 5'h00;
    endproperty
    a_irq_rd: assert property (p_irq_rd) else $error("event read top bits set");
    c_mst: cover property (!sck_oe_n && $changed(sck_o));
    c_irq: cover property ($rose(irq));
    c_ack: cover property (!sda_oe_n);
endmodule // sync_serial_spi_status_chk
bind sync_serial_spi_status sync_serial_spi_status_chk i_chk (.ref_clk, .rstn, .addr,
    .rd_en, .rdata, .irq, .sck_o, .sck_oe_n, .sdo_oe_n, .sda_oe_n);
`default_nettype wire

/* dv/sync_serial_spi_status_test.sv */
// bench: register bus, spi master and slave, i2c slave status flags
// assumes spi_peer and the defines header; pins resolved here
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_spi_status_defs.vh"
module sync_serial_spi_status_test;
    logic       ref_clk = 1'b0;
    logic       rstn    = 1'b0;
    logic [3:0] addr    = 4'h0;
    logic [7:0] wdata   = 8'h00;
    logic       wr_en   = 1'b0;
    logic       rd_en   = 1'b0;
    logic       sck_m   = 1'b0;
    logic       sdi_m   = 1'b1;
    logic       ss_n    = 1'b1;
    logic       p_cke   = 1'b0;
    logic       p_load  = 1'b0;
    logic [7:0] p_tx    = 8'h00;
    wire  [7:0] rdata, p_rx;
    wire        irq, sck_o, sck_oe_n, sdo_o, sdo_oe_n, sda_o, sda_oe_n, p_sdi;
    wire        sck_i = sck_oe_n ? sck_m : sck_o;
    // open drain: sda low when either side pulls
    wire        sdi_i = (sck_oe_n ? sdi_m : p_sdi) & (sda_oe_n | sda_o);
    int         miscompares = 0;
    int         n_tests = 0;
    always #10 ref_clk = ~ref_clk;
    sync_serial_spi_status i_dut (.ref_clk, .rstn, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .irq, .sck_i, .sck_o, .sck_oe_n, .sdi_i, .sdo_o, .sdo_oe_n, .ss_n_i(ss_n), .sda_o,
        .sda_oe_n);
    spi_peer i_peer (.sck(sck_i), .act(!sck_oe_n), .cke(p_cke), .load(p_load), .tx(p_tx),
        .sdo(sdo_o), .sdi(p_sdi), .rx(p_rx));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task automatic gap(output int n);
        logic s;
        s = sck_o;
        n = 0;
        while (sck_o === s && n < 99) begin
            @(posedge ref_clk);
            #1 n++;
        end
    endtask
    task automatic t_rate;
        int n;
        int h [4] = '{2, 8, 32, 32};
        wr(`ADR_IRQ_MASK, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wr(`ADR_CONTROL, 8'h20 | m[7:0]);
            wr(`ADR_BUFFER, 8'h00);
            #1 gap(n);
            gap(n);
            chk(n[7:0], h[m][7:0]);
            chk({7'h00, sck_oe_n}, 8'h00);
            n = 0;
            while (irq !== 1'b1 && n < 700) begin
                @(posedge ref_clk);
                n++;
            end
            rc(`ADR_IRQ_STAT, 8'h01, 8'h01);
            rc(`ADR_BUFFER, 8'h00, 8'h00);
        end
    endtask
    task automatic t_xfer(input logic cke);
        p_cke <= cke;
        p_tx <= 8'hA5;
        wr(`ADR_IRQ_MASK, 8'h00);
        wr(`ADR_STATUS, {1'b0, cke, 6'h00});
        wr(`ADR_CONTROL, 8'h22);
        p_load <= 1'b1;
        wr(`ADR_BUFFER, 8'h3C);
        p_load <= 1'b0;
        // 17 ticks of 32 cycles; masked so irq stays low
        tick(600);
        chk({7'h00, irq}, 8'h00);
        wr(`ADR_IRQ_MASK, 8'h01);
        #1 chk({7'h00, irq}, 8'h01);
        chk(p_rx, 8'h3C);
        rc(`ADR_STATUS, 8'h01, 8'h01);
        rc(`ADR_BUFFER, 8'hFF, 8'hA5);
        rc(`ADR_STATUS, 8'h01, 8'h00);
        rc(`ADR_IRQ_STAT, 8'h07, 8'h01);
        chk({7'h00, irq}, 8'h00);
    endtask
    task automatic t_slave;
        logic [7:0] got;
        logic [7:0] b;
        b = 8'h96;
        wr(`ADR_CONTROL, 8'h00);
        wr(`ADR_STATUS, 8'h40);
        wr(`ADR_CONTROL, 8'h24); // clock already idle low
        rc(`ADR_PINS, 8'h01, 8'h00);
        chk({7'h00, sdo_oe_n}, 8'h01);
        ss_n <= 1'b0;
        wr(`ADR_BUFFER, 8'hC3);
        tick(4);
        for (int i = 7; i >= 0; i--) begin
            sdi_m <= b[i];
            tick(4);
            sck_m <= 1'b1;
            got[i] = sdo_o;
            tick(4);
            sck_m <= 1'b0;
        end
        tick(8);
        chk(got, 8'hC3);
        chk({sdo_oe_n, sck_oe_n}, 8'h01);
        rc(`ADR_STATUS, 8'h01, 8'h01);
        rc(`ADR_BUFFER, 8'hFF, 8'h96);
        ss_n <= 1'b1;
        sdi_m <= 1'b1;
        wr(`ADR_CONTROL, 8'h25);
        #1 chk({7'h00, sdo_oe_n}, 8'h00);
    endtask
    task automatic i2c_bit(input logic v, output logic s);
        sdi_m <= v;
        tick(2);
        sck_m <= 1'b1;
        tick(4);
        s = sdi_i;
        sck_m <= 1'b0;
        tick(2);
    endtask
    task automatic i2c_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) i2c_bit(b[i], s);
        i2c_bit(1'b1, s);
        chk({7'h00, s}, 8'h00);
    endtask
    // start when stp is 0, stop when 1
    task automatic i2c_cond(input logic stp);
        sdi_m <= !stp;
        tick(2);
        sck_m <= 1'b1;
        tick(4);
        sdi_m <= stp;
        tick(4);
        if (!stp) sck_m <= 1'b0;
        tick(2);
    endtask
    task automatic t_i2c;
        logic [7:0] got;
        logic       s;
        wr(`ADR_CONTROL, 8'h00);
        wr(`ADR_STATUS, 8'h00);
        wr(`ADR_OWN_ADDR, 8'h84);
        wr(`ADR_CONTROL, 8'h26);
        i2c_cond(1'b0);
        rc(`ADR_STATUS, 8'h18, 8'h08);
        i2c_byte(8'h84);
        rc(`ADR_STATUS, 8'h3F, 8'h09);
        rc(`ADR_BUFFER, 8'hFF, 8'h84);
        i2c_byte(8'h5A);
        rc(`ADR_STATUS, 8'h3F, 8'h29);
        rc(`ADR_BUFFER, 8'hFF, 8'h5A);
        i2c_cond(1'b1);
        rc(`ADR_STATUS, 8'h1C, 8'h10);
        i2c_cond(1'b0);
        rc(`ADR_STATUS, 8'h18, 8'h08);
        // no clock stretching, so the read byte is loaded before the address
        wr(`ADR_BUFFER, 8'h3C);
        i2c_byte(8'h85);
        rc(`ADR_STATUS, 8'h3F, 8'h0D);
        for (int i = 7; i >= 0; i--) i2c_bit(1'b1, got[i]);
        i2c_bit(1'b1, s);
        chk(got, 8'h3C);
        chk({7'h00, s}, 8'h01);
        rc(`ADR_STATUS, 8'h05, 8'h04);
        rc(`ADR_IRQ_STAT, 8'h06, 8'h06);
        wr(`ADR_CONTROL, 8'h06);
        rc(`ADR_STATUS, 8'h18, 8'h00);
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        tick(10);
        rstn <= 1'b1;
        rc(`ADR_STATUS, 8'hFF, 8'h00);
        chk({irq, sck_oe_n, sdo_oe_n, sda_oe_n}, 8'h07);
        wr(`ADR_STATUS, 8'hFF);
        rc(`ADR_STATUS, 8'hFF, 8'hC0);
        wr(`ADR_CONTROL, 8'hDF);
        rc(`ADR_CONTROL, 8'hFF, 8'h1F);
        rc(4'hF, 8'hFF, 8'h00);
        wr(`ADR_STATUS, 8'h00);
        t_rate;
        t_xfer(1'b1);
        t_xfer(1'b0);
        t_slave;
        t_i2c;
        wrap_up;
    end
    // about 3k cycles expected; cut off well beyond
    initial begin
        #400000;
        miscompares++;
        wrap_up;
    end
endmodule // sync_serial_spi_status_test
`default_nettype wire
